// [inc/anp_pkg.sv]
// Package for the next-page register bank: offsets, field positions, reset values, carriers.
// Assumes a management register port with 5-bit register address and 16-bit data.
package anp_pkg;
  localparam logic [4:0]  REG_EXPANSION  = 5'h06;
  localparam logic [4:0]  REG_NP_TX      = 5'h07;
  localparam logic [4:0]  REG_NP_PARTNER = 5'h08;
  localparam int          BIT_PD_FAULT   = 4;
  localparam int          BIT_LP_NP_ABLE = 3;
  localparam int          BIT_NP_ABLE    = 2;
  localparam int          BIT_PAGE_RX    = 1;
  localparam int          BIT_LP_AN_ABLE = 0;
  localparam int          BIT_MORE       = 15;
  localparam int          BIT_MSG        = 13;
  localparam int          BIT_ACK2       = 12;
  localparam int          BIT_TOGGLE     = 11;
  localparam int          CODE_W         = 11;
  localparam logic        RST_MORE       = 1'b0;
  localparam logic        RST_MSG        = 1'b1;
  localparam logic        RST_ACK2       = 1'b0;
  localparam logic [10:0] RST_CODE       = 11'h001;
  localparam logic [15:0] RST_PARTNER    = 16'h0000;

  typedef struct packed {
    logic        more;
    logic        msg;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } anp_page_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } anp_req_t;
endpackage

// [rtl/anp_latch_high.sv]
// Latch-high status flag cleared by a read of its register.
// Assumes event and read strobe are synchronous to clk; set wins over clear.
`timescale 1ns/100ps
module anp_latch_high (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Event and clear
  input  wire logic set_evt,
  input  wire logic rd_clr,
  // Flag
  output logic      flag_ff
);
  wire logic nxt_flag;

  assign nxt_flag = set_evt | (flag_ff & ~rd_clr);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flag_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
    end
  end
endmodule

// [rtl/anp_regs.sv]
// Auto-negotiation expansion, next-page transmit and partner next-page registers.
// Assumes the management serial engine issues one-cycle rd/wr strobes and samples rdata one cycle after rd.
`timescale 1ns/100ps
module anp_regs (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Management register port
  input  wire anp_pkg::anp_req_t  req,
  output logic [15:0]             rdata_ff,
  // Negotiation engine
  input  wire logic               pd_fault_evt,
  input  wire logic               page_rx_stb,
  input  wire anp_pkg::anp_page_t page_rx,
  input  wire logic               lp_np_able,
  input  wire logic               lp_an_able,
  input  wire logic               tx_toggle,
  output anp_pkg::anp_page_t      np_tx_ff
);
  logic                lp_np_able_ff;
  logic                lp_an_able_ff;
  logic                toggle_ff;
  logic [15:0]         partner_ff;
  logic                pd_fault_ff;
  logic                page_rx_ff;
  anp_pkg::anp_page_t  nxt_np_tx;
  logic [15:0]         nxt_rdata;

  // Register number match
  function automatic logic addr_hit(input logic [4:0] addr, input logic [4:0] reg_num);
    return (addr == reg_num);
  endfunction

  // Page fields to a register word; bit 14 always zero
  function automatic logic [15:0] page_word(input logic        more,
                                            input logic        msg,
                                            input logic        ack2,
                                            input logic        toggle,
                                            input logic [10:0] code);
    return {more, 1'b0, msg, ack2, toggle, code};
  endfunction

  wire logic        sel_exp = addr_hit(req.addr, anp_pkg::REG_EXPANSION);
  wire logic        sel_tx  = addr_hit(req.addr, anp_pkg::REG_NP_TX);
  wire logic        sel_lp  = addr_hit(req.addr, anp_pkg::REG_NP_PARTNER);
  wire logic        rd_exp  = req.rd & sel_exp;
  wire logic        wr_tx   = req.wr & sel_tx;
  wire logic [15:0] exp_word;
  wire logic [15:0] tx_word;
  wire logic [15:0] rx_word;

  anp_latch_high u_pd_fault (
    .clk     (clk),
    .rst_n   (rst_n),
    .set_evt (pd_fault_evt),
    .rd_clr  (rd_exp),
    .flag_ff (pd_fault_ff)
  );

  anp_latch_high u_page_rx (
    .clk     (clk),
    .rst_n   (rst_n),
    .set_evt (page_rx_stb),
    .rd_clr  (rd_exp),
    .flag_ff (page_rx_ff)
  );

  // Expansion word; reserved bits zero
  assign exp_word = {11'h000, pd_fault_ff, lp_np_able_ff, 1'b1, page_rx_ff, lp_an_able_ff};

  // Transmit word; bit 14 zero, toggle from engine
  assign tx_word = page_word(np_tx_ff.more, np_tx_ff.msg, np_tx_ff.ack2, toggle_ff, np_tx_ff.code);

  // Received page word; bit 14 zero
  assign rx_word = page_word(page_rx.more, page_rx.msg, page_rx.ack2, page_rx.toggle, page_rx.code);

  // Writable fields of transmit register
  always_comb begin
    nxt_np_tx = np_tx_ff;
    if (wr_tx) begin
      nxt_np_tx.more = req.wdata[anp_pkg::BIT_MORE];
      nxt_np_tx.msg  = req.wdata[anp_pkg::BIT_MSG];
      nxt_np_tx.ack2 = req.wdata[anp_pkg::BIT_ACK2];
      nxt_np_tx.code = req.wdata[anp_pkg::CODE_W-1:0];
    end
    nxt_np_tx.toggle = toggle_ff;
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    nxt_rdata = 16'h0000;
    if (req.rd) begin
      if (sel_exp) begin
        nxt_rdata = exp_word;
      end else if (sel_tx) begin
        nxt_rdata = tx_word;
      end else if (sel_lp) begin
        nxt_rdata = partner_ff;
      end
    end
  end

  // Transmit page register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      np_tx_ff <= '{more: anp_pkg::RST_MORE, msg: anp_pkg::RST_MSG, ack2: anp_pkg::RST_ACK2,
                    toggle: 1'b0, code: anp_pkg::RST_CODE};
    end else begin
      np_tx_ff <= nxt_np_tx;
    end
  end

  // Status levels from the negotiation engine
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggle_ff     <= 1'b0;
      lp_np_able_ff <= 1'b0;
      lp_an_able_ff <= 1'b0;
    end else begin
      toggle_ff     <= tx_toggle;
      lp_np_able_ff <= lp_np_able;
      lp_an_able_ff <= lp_an_able;
    end
  end

  // Partner page register, loaded on each received page
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      partner_ff <= anp_pkg::RST_PARTNER;
    end else if (page_rx_stb) begin
      partner_ff <= rx_word;
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
endmodule

// [tb/anp_regs_monitor.sv]
// Port checker for anp_regs.
// Bound to every anp_regs instance.
`timescale 1ns/100ps
module anp_regs_monitor (
  // Watched ports
  input logic               clk,
  input logic               rst_n,
  input anp_pkg::anp_req_t  req,
  input logic [15:0]        rdata_ff,
  input logic               pd_fault_evt,
  input logic               page_rx_stb,
  input anp_pkg::anp_page_t page_rx,
  input logic               lp_np_able,
  input logic               lp_an_able,
  input logic               tx_toggle,
  input anp_pkg::anp_page_t np_tx_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire r6 = req.rd && req.addr == 5'h06;
  wire r7 = req.rd && req.addr == 5'h07;
  wire w7 = req.wr && req.addr == 5'h07;
  logic [15:0] pg_ff;
  always_ff @(posedge clk) pg_ff <= !rst_n ? 16'h0000 : page_rx_stb ? {page_rx[14], 1'b0, page_rx[13:0]} : pg_ff;
  exp_rd_a: assert property (r6 |=> rdata_ff[2] && rdata_ff[15:5] == 11'h000) else $error("reg6");
  pd_flag_a: assert property (pd_fault_evt ##1 !req.rd ##1 r6 |=> rdata_ff[4]) else $error("fault");
  rx_flag_a: assert property (page_rx_stb ##1 !req.rd ##1 r6 |=> rdata_ff[1]) else $error("page");
  lp_bits_a: assert property (r6 |=> rdata_ff[3] == $past(lp_np_able, 2) && rdata_ff[0] == $past(lp_an_able, 2))
    else $error("lp");
  tx_ctl_a: assert property (w7 |=> np_tx_ff[14:12] == $past({req.wdata[15], req.wdata[13:12]})) else $error("ctl");
  tx_code_a: assert property (w7 |=> np_tx_ff.code == $past(req.wdata[10:0])) else $error("code");
  tx_toggle_a: assert property (r7 |=> rdata_ff[11] == $past(tx_toggle, 2) && !rdata_ff[14]) else $error("tog");
  partner_a: assert property (req.rd && req.addr == 5'h08 |=> rdata_ff == $past(pg_ff)) else $error("reg8");
endmodule
bind anp_regs anp_regs_monitor anp_regs_monitor_inst (.*);

// [tb/anp_engine_model.sv]
// Engine model handing received pages to anp_regs.
// Between pages the page lines change every cycle.
`timescale 1ns/100ps
module anp_engine_model (
  // Engine side
  input  logic               clk,
  input  logic               send,
  input  anp_pkg::anp_page_t page_in,
  output anp_pkg::anp_page_t page_rx = '0,
  output logic               page_rx_stb = 1'b0
);
  always @(posedge clk) begin
    page_rx_stb <= send;
    page_rx <= send ? page_in : ~page_rx;
  end
endmodule

// [tb/anp_regs_tb.sv]
// Bench for anp_regs.
// Drives register accesses and engine events.
`timescale 1ns/100ps
module anp_regs_tb;
  logic               clk = 1'b0, rst_n = 1'b0, send = 1'b0, tx_toggle = 1'b0;
  logic               pd_fault_evt = 1'b0, lp_np_able = 1'b0, lp_an_able = 1'b0, page_rx_stb;
  logic [15:0]        rdata_ff;
  anp_pkg::anp_req_t  req = '0;
  anp_pkg::anp_page_t page_rx, np_tx_ff, page_in = 15'h5A5A;
  int                 fail_count = 0, check_count = 0;
  anp_regs anp_regs_inst (.*);
  anp_engine_model anp_engine_model_inst (.*);
  initial forever #50 clk = ~clk;
  task automatic stop_test();
    if (fail_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk) req <= '{1'b1, 1'b0, a, 16'h0000};
    @(posedge clk) req <= '0;
    #1 check_count++;
    if (rdata_ff !== e) begin
      fail_count++;
      $display("[FAIL] %0t reg %h got %h", $time, a, rdata_ff);
    end
  endtask
  task automatic chk_np(input anp_pkg::anp_page_t e);
    check_count++;
    if (np_tx_ff !== e) begin
      fail_count++;
      $display("[FAIL] %0t np_tx got %h", $time, np_tx_ff);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{1'b0, 1'b1, a, d};
    @(posedge clk) req <= '0;
  endtask
  task automatic t_regs();
    chk_np(15'h2001);
    rd(5'h07, 16'h2001);
    rd(5'h09, 16'h0000);
    wr(5'h07, 16'hFFFF);
    #1 chk_np(15'h77FF);
    wr(5'h06, 16'hFFFF);
    wr(5'h08, 16'hFFFF);
    rd(5'h07, 16'hB7FF);
    rd(5'h06, 16'h000D);
    rd(5'h08, 16'h9A5A);
    @(posedge clk) tx_toggle <= 1'b1;
    rd(5'h07, 16'hBFFF);
    chk_np(15'h7FFF);
  endtask
  task automatic t_clash();
    @(posedge clk) begin
      req          <= '{1'b1, 1'b0, 5'h06, 16'h0000};
      pd_fault_evt <= 1'b1;
    end
    @(posedge clk) begin
      req          <= '0;
      pd_fault_evt <= 1'b0;
    end
    #1 check_count++;
    if (rdata_ff !== 16'h000D) begin
      fail_count++;
      $display("[FAIL] %0t clash read got %h", $time, rdata_ff);
    end
    rd(5'h06, 16'h001D);
    rd(5'h06, 16'h000D);
  endtask
  task automatic t_events();
    rd(5'h06, 16'h0004);
    @(posedge clk) pd_fault_evt <= 1'b1;
    @(posedge clk) pd_fault_evt <= 1'b0;
    rd(5'h06, 16'h0014);
    rd(5'h06, 16'h0004);
    @(posedge clk) send <= 1'b1;
    @(posedge clk) send <= 1'b0;
    @(posedge clk) {lp_np_able, lp_an_able} <= 2'h3;
    rd(5'h06, 16'h000F);
    rd(5'h08, 16'h9A5A);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_events();
    t_clash();
    t_regs();
    stop_test();
  end
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
endmodule
